//--- inc/timer_defs.svh
// Offsets, field positions, reset values and codes for the split timer and its control register.
// Behaviour
// RL1: In split mode the first timer runs as two independent 8-bit counters.
// RL2: Split low byte uses first run, count select, gate and overflow flag.
// RL3: Split low byte counts system/prescaled clock or external input per count select.
// RL4: Split high byte is a timer only, never fed from an external pin.
// RL5: Split high byte counts only while the second run bit is set.
// RL6: Split high byte overflow sets the second overflow flag, bit 7.
// RL7: In split mode second timer runs modes 0-2, no external count, no flag.
// RL8: In split mode the second timer's overflow pulse still goes out.
// RL9: In split mode the second timer runs in modes 0-2, stops in mode 3.
// RL10: First overflow flag: set on overflow, software clears, vectoring clears.
// RL11: First external flag set on the edge or level its type selects.
// RL12: Software clears first external flag; vectoring clears it only in edge mode.
// RL13: First external flag shows the inverse of its pin level.
// RL14: Type select 0 means active-low level, 1 means falling edge.
// RL15: A running timer counts if gate is 0, or gate 1 and pin high.
// RL16: External counting advances once per falling edge of the count pin.
// RL17: The external count source holds each level two clock cycles at least.
// RL18: Outside split mode second flag set on overflow, cleared by software or vectoring.
// RL19: Second external flag behaves like the first with its own type and pin.
// RL20: Run bit 6 and bit 4 stop their timer at 0 and run it at 1.
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH
`define OFF_TCS 8'h00
`define OFF_TMR 8'h04
`define OFF_LO0 8'h08
`define OFF_HI0 8'h0C
`define OFF_LO1 8'h10
`define OFF_HI1 8'h14
`define OFF_CLK 8'h18
`define OFF_ACK 8'h1C
`define B_TF1 7
`define B_TR1 6
`define B_TF0 5
`define B_TR0 4
`define B_IE1 3
`define B_IT1 2
`define B_IE0 1
`define B_IT0 0
`define B_GATE1 7
`define B_CS1 6
`define B_M1 4
`define B_FIRST_GATE_ENABLE 3
`define B_CS0 2
`define B_M0 0
`define B_SYS0 0
`define B_SYS1 1
`define B_DIV 8
`define B_ACK_TF0 0
`define B_ACK_TF1 1
`define B_ACK_IE0 2
`define B_ACK_IE1 3
`define RST_BYTE 8'h00
`define RST_SEL 2'h0
`define RST_DIV 8'h0B
`define PIN_IDLE 1'b1
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

//--- inc/timer_pkg.sv
// Types shared by the timer block.
package timer_pkg;
	typedef enum logic [1:0] {MODE_13BIT, MODE_16BIT, MODE_8RELOAD, MODE_SPLIT} timer_mode_t;
	typedef logic [7:0] byte_t;
endpackage

//--- inc/pin_event_if.sv
// Filtered level and falling-edge pulse of one external pin.
`timescale 1ns/10ps
`default_nettype none
interface pin_event_if;
	logic level;
	logic fall;
	modport src (output level, fall);
	modport dst (input level, fall);
endinterface
`default_nettype wire

//--- design/pin_sync.sv
// Three-stage pin synchroniser with agreement filter and falling-edge pulse.
`timescale 1ns/10ps
`default_nettype none
`include "timer_defs.svh"
module pin_sync (
	input wire logic clk,
	input wire logic rst,
	input wire logic pinIn,
	pin_event_if.src ev
);
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;
	logic level_reg;
	logic fall_reg;

	always_ff @(posedge clk) begin
		if (rst) begin
			s1_reg <= `PIN_IDLE;
			s2_reg <= `PIN_IDLE;
			s3_reg <= `PIN_IDLE;
		end else begin
			s1_reg <= pinIn;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// A new level is taken only when two later stages agree, so a level must stand two cycles. [RL17]
	always_ff @(posedge clk) begin
		if (rst) begin
			level_reg <= `PIN_IDLE;
			fall_reg <= 1'b0;
		end else begin
			if (s2_reg == s3_reg) begin
				level_reg <= s3_reg;
			end
			fall_reg <= level_reg && (s2_reg == s3_reg) && !s3_reg;
		end
	end

	assign ev.level = level_reg;
	assign ev.fall = fall_reg;
endmodule // pin_sync
`default_nettype wire

//--- design/ext_irq_flag.sv
// One external interrupt flag with level or falling-edge sensing.
`timescale 1ns/10ps
`default_nettype none
module ext_irq_flag (
	input wire logic clk,
	input wire logic rst,
	pin_event_if.dst ev,
	input wire logic typeEdge,
	input wire logic swWrite,
	input wire logic swValue,
	input wire logic vecAck,
	output logic flag
);
	logic flag_reg;

	always_ff @(posedge clk) begin
		if (rst) begin
			flag_reg <= 1'b0;
		end else if (!typeEdge) begin
			// Level mode: the flag mirrors the inverted pin, so a clear does not stick. [RL13] [RL14]
			flag_reg <= !ev.level;
		end else begin
			// Edge mode: a falling edge wins over a clear in the same cycle. [RL11] [RL12] [RL14]
			flag_reg <= ev.fall || (swWrite ? swValue : (flag_reg && !vecAck));
		end
	end

	assign flag = flag_reg;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_levelFollow;
		!typeEdge |=> flag == !$past(ev.level);
	endproperty
	a_levelFollow: assert property (p_levelFollow) else $error("Level flag does not mirror the pin."); // [RL13]
	property p_edgeSet;
		typeEdge && ev.fall |=> flag;
	endproperty
	a_edgeSet: assert property (p_edgeSet) else $error("Falling edge did not set the flag."); // [RL11]
	property p_vecClear;
		typeEdge && vecAck && !ev.fall && !swWrite |=> !flag;
	endproperty
	a_vecClear: assert property (p_vecClear) else $error("Vectoring did not clear the edge flag."); // [RL12]
endmodule // ext_irq_flag
`default_nettype wire

//--- design/split_timer_control.sv
// Timers 0 and 1 with split mode, control register and AXI4-Lite register access.
//
// The address map and register access over AXI4-Lite were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "timer_defs.svh"
module split_timer_control (
	input wire logic clk,
	input wire logic rst,
	input wire logic awvalid,
	output logic awready,
	input wire logic [7:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [7:0] araddr,
	input wire logic [2:0] arprot,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	input wire logic firstExtIrqPin,
	input wire logic secondExtIrqPin,
	input wire logic firstCountInputPin,
	input wire logic secondCountInputPin,
	output logic secondOverflowPulse,
	output logic [3:0] flagState
);
	////////////////////////////////////////////////////////////////////////////////
	// Register bus.
	logic awHeld_reg;
	logic [7:0] awAddr_reg;
	logic wHeld_reg;
	logic [15:0] wData_reg;
	logic [1:0] wStrb_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;
	logic [7:0] wAddr;
	logic [7:0] wd;
	logic [15:0] wdFull;
	logic [1:0] wLanes;
	logic wLane;
	logic doWrite;
	logic [31:0] rdNext;

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a[1:0] == 2'h0) && (a <= `OFF_ACK);
	endfunction

	assign awready = !awHeld_reg && !bvalid_reg;
	assign wready = !wHeld_reg && !bvalid_reg;
	assign arready = !rvalid_reg;
	assign wAddr = awHeld_reg ? awAddr_reg : awaddr;
	// Two byte lanes are kept while W waits for AW, so an early divisor write is not lost.
	assign wdFull = wHeld_reg ? wData_reg : wdata[15:0];
	assign wLanes = wHeld_reg ? wStrb_reg : wstrb[1:0];
	assign wd = wdFull[7:0];
	assign wLane = wLanes[0];
	assign doWrite = (awHeld_reg || (awvalid && awready)) && (wHeld_reg || (wvalid && wready));

	always_ff @(posedge clk) begin
		if (rst) begin
			awHeld_reg <= 1'b0;
			awAddr_reg <= 8'h00;
			wHeld_reg <= 1'b0;
			wData_reg <= 16'h0000;
			wStrb_reg <= 2'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= `RESP_OKAY;
		end else if (doWrite) begin
			awHeld_reg <= 1'b0;
			wHeld_reg <= 1'b0;
			bvalid_reg <= 1'b1;
			bresp_reg <= mapped(wAddr) ? `RESP_OKAY : `RESP_SLVERR;
		end else begin
			if (awvalid && awready) begin
				awHeld_reg <= 1'b1;
				awAddr_reg <= awaddr;
			end
			if (wvalid && wready) begin
				wHeld_reg <= 1'b1;
				wData_reg <= wdata[15:0];
				wStrb_reg <= wstrb[1:0];
			end
			if (bvalid_reg && bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	assign bvalid = bvalid_reg;
	assign bresp = bresp_reg;

	logic wrTcs;
	logic wrTmr;
	logic wrLo0;
	logic wrHi0;
	logic wrLo1;
	logic wrHi1;
	logic wrClk;
	logic [3:0] ack;

	assign wrTcs = doWrite && wLane && (wAddr == `OFF_TCS);
	assign wrTmr = doWrite && wLane && (wAddr == `OFF_TMR);
	assign wrLo0 = doWrite && wLane && (wAddr == `OFF_LO0);
	assign wrHi0 = doWrite && wLane && (wAddr == `OFF_HI0);
	assign wrLo1 = doWrite && wLane && (wAddr == `OFF_LO1);
	assign wrHi1 = doWrite && wLane && (wAddr == `OFF_HI1);
	assign wrClk = doWrite && wLane && (wAddr == `OFF_CLK);
	// Writing ones here stands for the CPU vectoring to the matching interrupts.
	assign ack = (doWrite && wLane && (wAddr == `OFF_ACK)) ? wd[3:0] : 4'h0;

	////////////////////////////////////////////////////////////////////////////////
	// Configuration and pins.
	logic tr0_reg;
	logic tr1_reg;
	logic it0_reg;
	logic it1_reg;
	logic tf0_reg;
	logic tf1_reg;
	logic ie0;
	logic ie1;
	logic [7:0] mode_reg;
	logic [1:0] sys_reg;
	logic [7:0] div_reg;
	logic [7:0] preCnt_reg;

	always_ff @(posedge clk) begin
		if (rst) begin
			tr0_reg <= 1'b0;
			tr1_reg <= 1'b0;
			it0_reg <= 1'b0;
			it1_reg <= 1'b0;
			mode_reg <= `RST_BYTE;
			sys_reg <= `RST_SEL;
			div_reg <= `RST_DIV;
		end else begin
			if (wrTcs) begin
				tr0_reg <= wd[`B_TR0];
				tr1_reg <= wd[`B_TR1];
				it0_reg <= wd[`B_IT0];
				it1_reg <= wd[`B_IT1];
			end
			if (wrTmr) begin
				mode_reg <= wd;
			end
			if (wrClk) begin
				sys_reg <= wd[1:0];
			end
			if (doWrite && (wAddr == `OFF_CLK) && wLanes[1]) begin
				div_reg <= wdFull[`B_DIV +: 8];
			end
		end
	end

	pin_event_if int0Ev();
	pin_event_if int1Ev();
	pin_event_if cnt0Ev();
	pin_event_if cnt1Ev();
	pin_sync u_first_ext_irq_pin (.clk(clk), .rst(rst), .pinIn(firstExtIrqPin), .ev(int0Ev));
	pin_sync u_second_ext_irq_pin (.clk(clk), .rst(rst), .pinIn(secondExtIrqPin), .ev(int1Ev));
	pin_sync u_cnt0 (.clk(clk), .rst(rst), .pinIn(firstCountInputPin), .ev(cnt0Ev));
	pin_sync u_cnt1 (.clk(clk), .rst(rst), .pinIn(secondCountInputPin), .ev(cnt1Ev));

	// Second flag copies the first with its own type, pin and clears. [RL19]
	ext_irq_flag u_ie0 (.clk(clk), .rst(rst), .ev(int0Ev), .typeEdge(it0_reg), .swWrite(wrTcs),
		.swValue(wd[`B_IE0]), .vecAck(ack[`B_ACK_IE0]), .flag(ie0));
	ext_irq_flag u_ie1 (.clk(clk), .rst(rst), .ev(int1Ev), .typeEdge(it1_reg), .swWrite(wrTcs),
		.swValue(wd[`B_IE1]), .vecAck(ack[`B_ACK_IE1]), .flag(ie1));

	////////////////////////////////////////////////////////////////////////////////
	// Counting.
	timer_pkg::timer_mode_t m0;
	timer_pkg::timer_mode_t m1;
	logic split;
	logic preTick;
	logic clk0;
	logic clk1;
	logic en0;
	logic en1;
	logic adv0;
	logic adv1;
	logic hiAdv;
	logic hiOvf;
	logic ovf0;
	logic ovf1;
	logic [16:0] s0;
	logic [16:0] s1;
	timer_pkg::byte_t lo0_reg;
	timer_pkg::byte_t hi0_reg;
	timer_pkg::byte_t lo1_reg;
	timer_pkg::byte_t hi1_reg;

	// Returns {overflow, high, low} after one count step in the given mode.
	function automatic logic [16:0] step(input timer_pkg::timer_mode_t m, input logic [7:0] hi, lo);
		logic [13:0] t13;
		logic [16:0] t16;
		t13 = {1'b0, hi, lo[4:0]} + 14'h0001;
		t16 = {1'b0, hi, lo} + 17'h00001;
		case (m)
			timer_pkg::MODE_13BIT: step = {t13[13], t13[12:5], lo[7:5], t13[4:0]};
			timer_pkg::MODE_16BIT: step = t16;
			timer_pkg::MODE_8RELOAD: step = {&lo, hi, ((&lo) ? hi : t16[7:0])};
			default: step = {&lo, hi, t16[7:0]};
		endcase
	endfunction

	assign m0 = timer_pkg::timer_mode_t'(mode_reg[`B_M0 +: 2]);
	assign m1 = timer_pkg::timer_mode_t'(mode_reg[`B_M1 +: 2]);
	assign split = (m0 == timer_pkg::MODE_SPLIT); // [RL1]
	assign preTick = (preCnt_reg == div_reg);
	assign clk0 = sys_reg[`B_SYS0] || preTick;
	assign clk1 = sys_reg[`B_SYS1] || preTick;
	// Run bits gate each timer except the second timer in split mode, with the gate bit handing control to the pin. [RL15] [RL20] [RL2]
	assign en0 = tr0_reg && (!mode_reg[`B_FIRST_GATE_ENABLE] || int0Ev.level);
	// In split mode the second timer runs by its mode field alone. [RL9]
	assign en1 = split ? (m1 != timer_pkg::MODE_SPLIT) :
		(tr1_reg && (!mode_reg[`B_GATE1] || int1Ev.level) && (m1 != timer_pkg::MODE_SPLIT)); // [RL20]
	// External counting advances on a filtered falling edge. [RL3] [RL16]
	assign adv0 = en0 && (mode_reg[`B_CS0] ? cnt0Ev.fall : clk0);
	// The second timer loses its external input while split mode is on. [RL7]
	assign adv1 = en1 && ((mode_reg[`B_CS1] && !split) ? cnt1Ev.fall : clk1);
	// The split high byte is a pure timer enabled by the second run bit. [RL4] [RL5]
	assign hiAdv = split && tr1_reg && clk0;
	assign hiOvf = hiAdv && (&hi0_reg);
	assign s0 = step(m0, hi0_reg, lo0_reg);
	assign s1 = step(m1, hi1_reg, lo1_reg);
	assign ovf0 = adv0 && s0[16];
	assign ovf1 = adv1 && s1[16];

	always_ff @(posedge clk) begin
		if (rst || preTick) begin
			preCnt_reg <= 8'h00;
		end else begin
			preCnt_reg <= preCnt_reg + 8'h01;
		end
	end

	// A bus write to a count byte takes priority over counting.
	always_ff @(posedge clk) begin
		if (rst) begin
			lo0_reg <= `RST_BYTE;
			hi0_reg <= `RST_BYTE;
		end else begin
			if (wrLo0) begin
				lo0_reg <= wd;
			end else if (adv0) begin
				lo0_reg <= s0[7:0]; // [RL1]
			end
			if (wrHi0) begin
				hi0_reg <= wd;
			end else if (hiAdv) begin
				hi0_reg <= hi0_reg + 8'h01; // [RL1]
			end else if (adv0 && !split) begin
				hi0_reg <= s0[15:8];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			lo1_reg <= `RST_BYTE;
			hi1_reg <= `RST_BYTE;
		end else begin
			if (wrLo1) begin
				lo1_reg <= wd;
			end else if (adv1) begin
				lo1_reg <= s1[7:0];
			end
			if (wrHi1) begin
				hi1_reg <= wd;
			end else if (adv1) begin
				hi1_reg <= s1[15:8];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Overflow flags and the second timer's overflow pulse.
	always_ff @(posedge clk) begin
		if (rst) begin
			tf0_reg <= 1'b0;
			tf1_reg <= 1'b0;
			secondOverflowPulse <= 1'b0;
		end else begin
			// Hardware sets win over software or vectoring clears. [RL10] [RL2]
			tf0_reg <= ovf0 || (wrTcs ? wd[`B_TF0] : (tf0_reg && !ack[`B_ACK_TF0]));
			// Split mode hands the second flag to the high byte. [RL6] [RL7] [RL18]
			tf1_reg <= (split ? hiOvf : ovf1) || (wrTcs ? wd[`B_TF1] : (tf1_reg && !ack[`B_ACK_TF1]));
			secondOverflowPulse <= ovf1; // [RL8]
		end
	end

	assign flagState = {tf1_reg, tf0_reg, ie1, ie0};

	////////////////////////////////////////////////////////////////////////////////
	// Read path.
	always_comb begin
		rdNext = 32'h00000000;
		case (araddr)
			`OFF_TCS: rdNext[7:0] = {tf1_reg, tr1_reg, tf0_reg, tr0_reg, ie1, it1_reg, ie0, it0_reg};
			`OFF_TMR: rdNext[7:0] = mode_reg;
			`OFF_LO0: rdNext[7:0] = lo0_reg;
			`OFF_HI0: rdNext[7:0] = hi0_reg;
			`OFF_LO1: rdNext[7:0] = lo1_reg;
			`OFF_HI1: rdNext[7:0] = hi1_reg;
			`OFF_CLK: rdNext[15:0] = {div_reg, 6'h00, sys_reg};
			default: rdNext = 32'h00000000;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			rresp_reg <= `RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid_reg <= 1'b1;
			rdata_reg <= rdNext;
			rresp_reg <= mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
		end else if (rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	assign rvalid = rvalid_reg;
	assign rdata = rdata_reg;
	assign rresp = rresp_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Checks.
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_tf0Set;
		ovf0 |=> tf0_reg;
	endproperty
	a_tf0Set: assert property (p_tf0Set) else $error("First overflow did not set its flag."); // [RL10]
	property p_tf0Vec;
		ack[`B_ACK_TF0] && !ovf0 && !wrTcs |=> !tf0_reg;
	endproperty
	a_tf0Vec: assert property (p_tf0Vec) else $error("Vectoring did not clear first flag."); // [RL10]
	property p_hiHold;
		split && !tr1_reg && !wrHi0 |=> $stable(hi0_reg);
	endproperty
	a_hiHold: assert property (p_hiHold) else $error("Split high byte moved with run bit clear."); // [RL5]
	property p_tf1Split;
		split && tr1_reg && clk0 && (hi0_reg == 8'hFF) |=> tf1_reg;
	endproperty
	a_tf1Split: assert property (p_tf1Split) else $error("Split high overflow did not set flag."); // [RL6]
	property p_t1NoFlag;
		split && !tf1_reg && !hiOvf && !wrTcs |=> !tf1_reg;
	endproperty
	a_t1NoFlag: assert property (p_t1NoFlag) else $error("Second timer set its flag in split mode."); // [RL7]
	property p_pulse;
		split && (m1 == timer_pkg::MODE_8RELOAD) && sys_reg[`B_SYS1] && (lo1_reg == 8'hFF) && !wrLo1
			|=> secondOverflowPulse;
	endproperty
	a_pulse: assert property (p_pulse) else $error("Second overflow pulse missing in split mode."); // [RL8]
	property p_t1Stop;
		split && (m1 == timer_pkg::MODE_SPLIT) && !wrLo1 && !wrHi1 |=> $stable({hi1_reg, lo1_reg});
	endproperty
	a_t1Stop: assert property (p_t1Stop) else $error("Second timer ran in mode 3."); // [RL9]
	property p_gate;
		tr0_reg && mode_reg[`B_FIRST_GATE_ENABLE] && !int0Ev.level && !wrLo0 |=> $stable(lo0_reg);
	endproperty
	a_gate: assert property (p_gate) else $error("Gated timer counted with pin low."); // [RL15]
	property p_extCount;
		mode_reg[`B_CS0] && !cnt0Ev.fall && !wrLo0 |=> $stable(lo0_reg);
	endproperty
	a_extCount: assert property (p_extCount) else $error("Event counter moved without an edge."); // [RL16]

	c_splitHiOvf: cover property (split && hiOvf);
	c_ovf1Split: cover property (split && ovf1);
	c_write: cover property (bvalid && bready);
	c_read: cover property (rvalid && rready);
endmodule // split_timer_control
`default_nettype wire

//--- test/pin_model.sv
// Model of the external event and interrupt pins.
`timescale 1ns/10ps
`default_nettype none
module pin_model (
	input wire logic clk,
	input wire logic [1:0] irqLevel,
	input wire logic pulseReq,
	output logic firstExtIrqPin,
	output logic secondExtIrqPin,
	output logic firstCountInputPin,
	output logic secondCountInputPin,
	output logic busy
);
	logic [3:0] phase_reg = 4'h0;
	logic countLevel;
	always_ff @(posedge clk) begin
		if (pulseReq && phase_reg == 4'h0)
			phase_reg <= 4'h8;
		else if (phase_reg != 4'h0)
			phase_reg <= phase_reg - 4'h1;
	end
	// Each count level is held four cycles, twice the minimum the sampler needs.
	assign countLevel = !(phase_reg > 4'h4);
	assign firstCountInputPin = countLevel;
	assign secondCountInputPin = countLevel;
	assign firstExtIrqPin = irqLevel[0];
	assign secondExtIrqPin = irqLevel[1];
	assign busy = phase_reg != 4'h0;
endmodule // pin_model
`default_nettype wire

//--- test/tb_top.sv
// Self-checking bench for the split timer and its control register.
`timescale 1ns/10ps
`default_nettype none
`include "timer_defs.svh"
`define CHECK(nm, e, g) begin samplesChecked++; if ((g) !== (e)) begin fails++; $display("Error %s expected %h seen %h", nm, e, g); end end
module tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0] wstrb = 4'hF;
	logic [1:0] bresp, rresp;
	logic [1:0] irqLevel = 2'h3;
	logic pulseReq = 1'b0;
	logic p0, p1, c0, c1, busy, ovfPulse;
	logic [3:0] flagState;
	logic [31:0] d, seed = 32'h3FD963AC;
	logic [1:0] r;
	logic [7:0] rv;
	int fails = 0, samplesChecked = 0, pulseCount = 0, a, nv;
	always #5 clk = ~clk;
	always @(posedge clk) if (ovfPulse === 1'b1) pulseCount++;
	split_timer_control split_timer_control_i (.clk(clk), .rst(rst), .awvalid(awvalid), .awready(awready),
		.awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
		.arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .firstExtIrqPin(p0),
		.secondExtIrqPin(p1), .firstCountInputPin(c0), .secondCountInputPin(c1),
		.secondOverflowPulse(ovfPulse), .flagState(flagState));
	pin_model pin_model_i (.clk(clk), .irqLevel(irqLevel), .pulseReq(pulseReq), .firstExtIrqPin(p0),
		.secondExtIrqPin(p1), .firstCountInputPin(c0), .secondCountInputPin(c1), .busy(busy));
	////////////////////////////////////////////////////////////////////////////////
	task automatic conclude();
		$display("checks %0d mismatches %0d", samplesChecked, fails);
		if (fails == 0 && samplesChecked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic guard(input int n);
		if (n >= 100) begin
			fails++;
			conclude();
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] dt, output logic [1:0] rs);
		logic at, wt, got;
		int n;
		n = 0;
		got = 1'b0;
		@(posedge clk);
		awaddr <= ad;
		wdata <= dt;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			// What is seen here stands until the next rising edge, where each handshake completes.
			@(negedge clk);
			at = awvalid && awready;
			wt = wvalid && wready;
			got = (bvalid === 1'b1);
			rs = bresp;
			@(posedge clk);
			if (at) awvalid <= 1'b0;
			if (wt) wvalid <= 1'b0;
			if (got) bready <= 1'b0;
			n++;
		end while (!got && n < 100);
		guard(n);
	endtask
	task automatic wo(input logic [7:0] ad, input logic [31:0] dt);
		logic [1:0] rs;
		wr(ad, dt, rs);
	endtask
	task automatic rd(input logic [7:0] ad, output logic [31:0] dt, output logic [1:0] rs);
		logic t, got;
		int n;
		n = 0;
		got = 1'b0;
		@(posedge clk);
		araddr <= ad;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge clk);
			t = arvalid && arready;
			got = (rvalid === 1'b1);
			dt = rdata;
			rs = rresp;
			@(posedge clk);
			if (t) arvalid <= 1'b0;
			if (got) rready <= 1'b0;
			n++;
		end while (!got && n < 100);
		guard(n);
	endtask
	task automatic pulse();
		int n;
		n = 0;
		@(posedge clk);
		pulseReq <= 1'b1;
		@(posedge clk);
		pulseReq <= 1'b0;
		do begin
			@(negedge clk);
			n++;
		end while (busy && n < 100);
		guard(n);
	endtask
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [7:0] expCount(input logic [7:0] start, input int steps);
		return start + 8'(steps);
	endfunction
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		rd(`OFF_TCS, d, r);
		`CHECK("control reset", 32'h0, d)
		rd(`OFF_CLK, d, r);
		`CHECK("clock cfg reset", 32'h00000B00, d)
		rd(8'h20, d, r);
		`CHECK("unmapped read", `RESP_SLVERR, r)
		wr(8'h20, 32'h1, r);
		`CHECK("unmapped write", `RESP_SLVERR, r)
		$display("done registers");
		wo(`OFF_CLK, 32'h00000B03);
		wo(`OFF_TMR, 32'h03);
		wo(`OFF_LO0, 32'hF0);
		wo(`OFF_TCS, 32'h10);
		cyc(30);
		`CHECK("low byte overflow", 1'b1, flagState[2])
		`CHECK("high byte idle", 1'b0, flagState[3])
		wo(`OFF_TCS, 32'h0);
		cyc(2);
		`CHECK("first flag sw clear", 1'b0, flagState[2])
		wo(`OFF_TCS, 32'h20);
		cyc(2);
		`CHECK("first flag sw set", 1'b1, flagState[2])
		wo(`OFF_ACK, 32'h1);
		cyc(2);
		`CHECK("first flag vector clear", 1'b0, flagState[2])
		wo(`OFF_TMR, 32'h07);
		wo(`OFF_HI0, 32'hF0);
		wo(`OFF_TCS, 32'h40);
		cyc(30);
		`CHECK("high byte overflow", 1'b1, flagState[3])
		$display("done split bytes");
		// Reload value first, then the count, so overflows repeat every two cycles.
		wo(`OFF_TMR, 32'h63);
		wo(`OFF_HI1, 32'hFE);
		wo(`OFF_LO1, 32'hFE);
		wo(`OFF_TCS, 32'h0);
		a = pulseCount;
		cyc(20);
		`CHECK("second pulse in split", 1'b1, pulseCount != a)
		`CHECK("second flag in split", 1'b0, flagState[3])
		wo(`OFF_TMR, 32'h73);
		cyc(4);
		a = pulseCount;
		cyc(20);
		`CHECK("second stopped", 1'b1, pulseCount == a)
		wo(`OFF_TMR, 32'h20);
		wo(`OFF_TCS, 32'h40);
		cyc(20);
		`CHECK("second flag normal", 1'b1, flagState[3])
		wo(`OFF_TCS, 32'h80);
		wo(`OFF_ACK, 32'h2);
		cyc(2);
		`CHECK("second flag vector clear", 1'b0, flagState[3])
		$display("done second timer");
		wo(`OFF_TMR, 32'h07);
		for (int k = 0; k < 3; k++) begin
			seed = lfsr(seed);
			rv = (k == 0) ? 8'hFF : seed[7:0];
			nv = int'(seed[9:8]) + 1;
			wo(`OFF_LO0, {24'h0, rv});
			wo(`OFF_TCS, 32'h10);
			repeat (nv) pulse();
			cyc(8);
			wo(`OFF_TCS, 32'h0);
			rd(`OFF_LO0, d, r);
			`CHECK("event count", expCount(rv, nv), d[7:0])
		end
		$display("done event count");
		wo(`OFF_TMR, 32'h0B);
		wo(`OFF_LO0, 32'h0);
		irqLevel <= 2'h2;
		cyc(8);
		wo(`OFF_TCS, 32'h10);
		cyc(20);
		wo(`OFF_TCS, 32'h0);
		rd(`OFF_LO0, d, r);
		`CHECK("gated hold", 32'h0, d)
		irqLevel <= 2'h3;
		cyc(8);
		wo(`OFF_TCS, 32'h10);
		cyc(20);
		wo(`OFF_TCS, 32'h0);
		rd(`OFF_LO0, d, r);
		`CHECK("gated run", 1'b1, d[7:0] != 8'h0)
		$display("done gate");
		for (int i = 0; i < 2; i++) begin
			wo(`OFF_TCS, 32'h0);
			irqLevel <= (i == 0) ? 2'h2 : 2'h1;
			cyc(10);
			`CHECK("level flag low pin", 1'b1, flagState[i])
			irqLevel <= 2'h3;
			cyc(10);
			`CHECK("level flag high pin", 1'b0, flagState[i])
			wo(`OFF_TCS, (i == 0) ? 32'h1 : 32'h4);
			irqLevel <= (i == 0) ? 2'h2 : 2'h1;
			cyc(10);
			irqLevel <= 2'h3;
			cyc(10);
			`CHECK("edge flag kept", 1'b1, flagState[i])
			wo(`OFF_ACK, (i == 0) ? 32'h4 : 32'h8);
			cyc(2);
			`CHECK("edge flag vector clear", 1'b0, flagState[i])
		end
		$display("done external flags");
		conclude();
	end
endmodule // tb_top
`default_nettype wire
